// *** lpbk_pkg.sv ***
package lpbk_pkg;
   localparam logic [3:0]  ADDR_CTRL_A      = 4'h0;
   localparam logic [3:0]  ADDR_CTRL_B      = 4'h1;
   localparam logic [3:0]  ADDR_STATUS      = 4'h2;
   localparam int          BIT_SELF_TEST    = 0;
   localparam int          BIT_REM_LOOP     = 2;
   localparam int          BIT_BYPASS       = 3;
   localparam int          BIT_LM_LOOP      = 4;
   localparam int          BIT_EB_LOOP      = 5;
   localparam int          BIT_SCRUB        = 11;
   localparam int          BIT_OVERRIDE     = 15;
   localparam logic [15:0] CTRL_A_RESET     = 16'h0000;
   localparam logic [15:0] CTRL_B_RESET     = 16'h0000;
   localparam logic [15:0] CTRL_A_MASK      = 16'h7FBF;
   localparam logic [15:0] CTRL_B_MASK      = 16'h8000;
   localparam logic [9:0]  IDLE_BYTE        = 10'h3FF;
   localparam logic [9:0]  ZERO_BYTE        = 10'h000;

   typedef enum logic [1:0]
   {
      CM_OFF    = 2'b00,
      CM_MAINTENANCE = 2'b01,
      CM_ACTIVE = 2'b10,
      CM_OTHER  = 2'b11
   } cm_state_t;

   typedef enum logic [1:0]
   {
      SRC_SYMBOL = 2'b00,
      SRC_TX     = 2'b01,
      SRC_IDLE   = 2'b10
   } rx_src_t;

   typedef struct packed
   {
      logic       valid;
      logic [9:0] data;
   } byte_beat_t;
endpackage

// *** skid2.sv ***
`timescale 1ns/1ps
module skid2 #(
   parameter int WIDTH = 10
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   typedef struct packed
   {
      logic [1:0][WIDTH-1:0] mem;
      logic                  rd;
      logic                  wr;
      logic [1:0]            cnt;
   } skid_state_t;

   skid_state_t s_q;
   skid_state_t s_d;
   logic        push;
   logic        pop;

   assign in_ready  = (s_q.cnt != 2'h2);
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data  = s_q.mem[s_q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr          = ~s_q.wr;
      end
      if (pop)
      begin
         s_d.rd = ~s_q.rd;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

// *** phy_loopback_bypass_control.sv ***
`timescale 1ns/1ps
module phy_loopback_bypass_control (
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RESET_N,
   // Classic Wishbone slave
   input  wire logic                WB_CYC_I,
   input  wire logic                WB_STB_I,
   input  wire logic                WB_WE_I,
   input  wire logic [5:0]          WB_ADR_I,
   input  wire logic [3:0]          WB_SEL_I,
   input  wire logic [31:0]         WB_DAT_I,
   output      logic [31:0]         WB_DAT_O,
   output      logic                WB_ACK_O,
   output      logic                WB_ERR_O,
   // Connection manager and self test status
   input  wire lpbk_pkg::cm_state_t CM_STATE,
   input  wire logic                SELF_TEST_RUNNING,
   // Data inputs
   input  wire logic [9:0]          TX_BYTE,
   input  wire logic                TX_VALID,
   input  wire logic [9:0]          RECEIVED_SYMBOL_BYTE,
   // Steering outputs to the receive path
   output      logic                PRE_FRAMER_LOOP_SEL,
   output      logic                LINE_MONITOR_LOOP_SEL,
   output      logic                FRAMER_CLOCK_LOCAL_SEL,
   output      logic [1:0]          BYPASS_SOURCE,
   // Receive byte output and transmit ready toward the MAC
   output      logic [9:0]          RX_BYTE,
   output      logic                RX_VALID,
   input  wire logic                RX_READY,
   output      logic                TX_READY
);
   typedef struct packed
   {
      logic [15:0]                ctrl_a;
      logic [15:0]                ctrl_b;
      logic [31:0]                rdata;
      logic                       ack;
      logic                       err;
      logic                       pre_loop;
      logic                       lm_loop;
      logic                       clk_local;
      lpbk_pkg::rx_src_t          src;
      lpbk_pkg::byte_beat_t       rx;
      logic                       tx_ready;
      logic [1:0]                 cm_meta;
      logic [1:0]                 cm_sync;
      logic                       built_in_self_test_meta;
      logic                       built_in_self_test_sync;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   logic              req;
   logic              loop_writable;
   logic              bit_control;
   logic [15:0]       wr_a;
   logic [15:0]       new_a;
   lpbk_pkg::cm_state_t cm_now;
   logic              buf_in_valid;
   logic              buf_in_ready;
   logic [9:0]        buf_in_data;
   logic              buf_out_valid;
   logic [9:0]        buf_out_data;

   // Merges a 16-bit write into a register under the byte enables.
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] sel);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   assign cm_now        = lpbk_pkg::cm_state_t'(s_q.cm_sync);
   assign req           = WB_CYC_I && WB_STB_I && !s_q.ack && !s_q.err;
   assign loop_writable = (cm_now == lpbk_pkg::CM_OFF) || (cm_now == lpbk_pkg::CM_MAINTENANCE);
   assign bit_control   = (cm_now == lpbk_pkg::CM_MAINTENANCE) || s_q.ctrl_b[lpbk_pkg::BIT_OVERRIDE];
   assign wr_a          = merge16(s_q.ctrl_a, WB_DAT_I[15:0], WB_SEL_I[1:0]) & lpbk_pkg::CTRL_A_MASK;

   // The EB and LM loopback bits keep their old value when the connection manager refuses the write.
   always_comb
   begin
      new_a = wr_a;
      if (!loop_writable)
      begin
         new_a[lpbk_pkg::BIT_EB_LOOP] = s_q.ctrl_a[lpbk_pkg::BIT_EB_LOOP];
         new_a[lpbk_pkg::BIT_LM_LOOP] = s_q.ctrl_a[lpbk_pkg::BIT_LM_LOOP];
      end
   end

   // The receive byte source is chosen before the buffer; with the symbol or idle source a stall drops words.
   always_comb
   begin
      buf_in_data  = RECEIVED_SYMBOL_BYTE;
      buf_in_valid = 1'b1;
      case (s_q.src)
         lpbk_pkg::SRC_IDLE:
         begin
            buf_in_data = lpbk_pkg::IDLE_BYTE;
         end
         lpbk_pkg::SRC_TX:
         begin
            buf_in_data  = TX_BYTE;
            buf_in_valid = TX_VALID;
         end
         default:
         begin
            buf_in_data = RECEIVED_SYMBOL_BYTE;
         end
      endcase
   end

   skid2 #(
      .WIDTH (10)
   ) u_buf (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (RX_READY || !s_q.rx.valid),
      .out_data  (buf_out_data)
   );

   always_comb
   begin
      s_d           = s_q;
      s_d.cm_meta   = CM_STATE;
      s_d.cm_sync   = s_q.cm_meta;
      s_d.built_in_self_test_meta = SELF_TEST_RUNNING;
      s_d.built_in_self_test_sync = s_q.built_in_self_test_meta;
      s_d.ack       = 1'b0;
      s_d.err       = 1'b0;
      if (req)
      begin
         s_d.rdata = 32'h0000_0000;
         case (WB_ADR_I[5:2])
            lpbk_pkg::ADDR_CTRL_A:
            begin
               s_d.ack = 1'b1;
               if (WB_WE_I)
               begin
                  s_d.ctrl_a = new_a;
               end
               s_d.rdata = {16'h0000, s_q.ctrl_a};
            end
            lpbk_pkg::ADDR_CTRL_B:
            begin
               s_d.ack = 1'b1;
               if (WB_WE_I)
               begin
                  s_d.ctrl_b = merge16(s_q.ctrl_b, WB_DAT_I[15:0], WB_SEL_I[1:0]) & lpbk_pkg::CTRL_B_MASK;
               end
               s_d.rdata = {16'h0000, s_q.ctrl_b};
            end
            lpbk_pkg::ADDR_STATUS:
            begin
               s_d.ack   = 1'b1;
               s_d.rdata = {22'h000000, s_q.src, s_q.clk_local, s_q.lm_loop, s_q.pre_loop,
                            s_q.built_in_self_test_sync, bit_control, loop_writable, s_q.cm_sync};
            end
            default:
            begin
               s_d.err = 1'b1;
            end
         endcase
      end
      // Self test forces the pre-framer path; the clock follows only the EB loop bit, not self test.
      s_d.pre_loop  = s_q.ctrl_a[lpbk_pkg::BIT_EB_LOOP] || s_q.built_in_self_test_sync;
      s_d.clk_local = s_q.ctrl_a[lpbk_pkg::BIT_EB_LOOP];
      s_d.lm_loop   = s_q.ctrl_a[lpbk_pkg::BIT_LM_LOOP];
      if (bit_control && s_q.ctrl_a[lpbk_pkg::BIT_BYPASS] && s_q.ctrl_a[lpbk_pkg::BIT_SCRUB])
      begin
         s_d.src = lpbk_pkg::SRC_IDLE;
      end
      else if (bit_control && s_q.ctrl_a[lpbk_pkg::BIT_BYPASS])
      begin
         s_d.src = lpbk_pkg::SRC_TX;
      end
      else
      begin
         s_d.src = lpbk_pkg::SRC_SYMBOL;
      end
      if (RX_READY || !s_q.rx.valid)
      begin
         s_d.rx.valid = buf_out_valid;
         s_d.rx.data  = buf_out_valid ? buf_out_data : lpbk_pkg::ZERO_BYTE;
      end
      // Transmit is only held off while it is the selected source and the buffer is full.
      s_d.tx_ready = buf_in_ready || (s_d.src != lpbk_pkg::SRC_TX);
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         s_q        <= '0;
         s_q.ctrl_a <= lpbk_pkg::CTRL_A_RESET;
         s_q.ctrl_b <= lpbk_pkg::CTRL_B_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Setting the EB loop bit switches the framer clock; software must tolerate the glitch.
   assign WB_DAT_O               = s_q.rdata;
   assign WB_ACK_O               = s_q.ack;
   assign WB_ERR_O               = s_q.err;
   assign PRE_FRAMER_LOOP_SEL    = s_q.pre_loop;
   assign LINE_MONITOR_LOOP_SEL  = s_q.lm_loop;
   assign FRAMER_CLOCK_LOCAL_SEL = s_q.clk_local;
   assign BYPASS_SOURCE          = s_q.src;
   assign RX_BYTE                = s_q.rx.data;
   assign RX_VALID               = s_q.rx.valid;
   assign TX_READY               = s_q.tx_ready;
endmodule

// *** lpbk_asserts.sv ***
`timescale 1ns/1ps
module lpbk_asserts (
   // Clock and reset
   input wire logic                CLK,
   input wire logic                RESET_N,
   // Register bus
   input wire logic                WB_CYC_I,
   input wire logic                WB_STB_I,
   input wire logic                WB_ACK_O,
   input wire logic                WB_ERR_O,
   // Status and data
   input wire lpbk_pkg::cm_state_t CM_STATE,
   input wire logic                SELF_TEST_RUNNING,
   input wire logic [9:0]          RECEIVED_SYMBOL_BYTE,
   input wire logic                PRE_FRAMER_LOOP_SEL,
   input wire logic                LINE_MONITOR_LOOP_SEL,
   input wire logic                FRAMER_CLOCK_LOCAL_SEL,
   input wire logic [1:0]          BYPASS_SOURCE,
   input wire logic [9:0]          RX_BYTE,
   input wire logic                RX_VALID,
   input wire logic                RX_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   AST_ANSWER: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O |=> WB_ACK_O || WB_ERR_O)
      else $error("bus request not answered in one cycle");
   AST_PULSE: assert property (WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O)
      else $error("bus answer longer than one cycle");
   AST_SELF_TEST: assert property (SELF_TEST_RUNNING [*5] |-> PRE_FRAMER_LOOP_SEL)
      else $error("self test without pre-framer loop");
   AST_CLOCK_SEL: assert property (FRAMER_CLOCK_LOCAL_SEL |-> PRE_FRAMER_LOOP_SEL)
      else $error("local framer clock without pre-framer loop");
   // Six samples leave room for a write taken just before the state change.
   AST_LOCKED: assert property ((CM_STATE == lpbk_pkg::CM_ACTIVE) [*6] |->
      $stable(LINE_MONITOR_LOOP_SEL) && $stable(FRAMER_CLOCK_LOCAL_SEL))
      else $error("loop bit changed while locked");
   AST_RX_HOLD: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_BYTE))
      else $error("receive word lost during stall");
   AST_IDLE: assert property ((BYPASS_SOURCE == lpbk_pkg::SRC_IDLE && RX_READY) [*6] |->
      RX_VALID && RX_BYTE == lpbk_pkg::IDLE_BYTE)
      else $error("idle source gives other word");
   AST_SYMBOL: assert property ((BYPASS_SOURCE == lpbk_pkg::SRC_SYMBOL && RX_READY
      && $stable(RECEIVED_SYMBOL_BYTE)) [*6] |-> RX_VALID && RX_BYTE == RECEIVED_SYMBOL_BYTE)
      else $error("symbol source gives other word");
endmodule
bind phy_loopback_bypass_control lpbk_asserts u_lpbk_asserts (.CLK(CLK), .RESET_N(RESET_N),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
   .CM_STATE(CM_STATE), .SELF_TEST_RUNNING(SELF_TEST_RUNNING),
   .RECEIVED_SYMBOL_BYTE(RECEIVED_SYMBOL_BYTE), .PRE_FRAMER_LOOP_SEL(PRE_FRAMER_LOOP_SEL),
   .LINE_MONITOR_LOOP_SEL(LINE_MONITOR_LOOP_SEL), .FRAMER_CLOCK_LOCAL_SEL(FRAMER_CLOCK_LOCAL_SEL),
   .BYPASS_SOURCE(BYPASS_SOURCE), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .RX_READY(RX_READY));

// *** lpbk_far_end.sv ***
`timescale 1ns/1ps
module lpbk_far_end (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Bench controls
   input  wire logic       stall,
   input  wire logic       freeze,
   // Transmit source and receive sink
   input  wire logic       tx_ready,
   output      logic [9:0] tx_byte,
   output      logic       tx_valid,
   output      logic       rx_ready
);
   assign rx_ready = !stall;
   // The source holds its word while refused, so a late ready loses nothing.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_byte  <= 10'h0A0;
         tx_valid <= 1'b0;
      end
      else
      begin
         tx_valid <= 1'b1;
         if (tx_valid && tx_ready && !freeze)
            tx_byte <= tx_byte + 10'h001;
      end
   end
endmodule

// *** phy_loopback_bypass_control_bench.sv ***
`timescale 1ns/1ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module phy_loopback_bypass_control_bench;
   logic                clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [5:0]          adr = 6'h00;
   logic [31:0]         dat_i = 32'h0, dat_o, rd;
   logic                ack, err, got_err, pre, lm, clk_loc, rx_valid, tx_ready, tx_valid, rx_ready;
   lpbk_pkg::cm_state_t cm = lpbk_pkg::CM_OFF;
   logic                st = 1'b0, stall = 1'b0, freeze = 1'b0;
   logic [9:0]          tx_byte, rx_byte, sym = 10'h155, exp_b;
   logic [1:0]          src;
   logic [15:0]         ctl [3] = '{16'h0808, 16'h0008, 16'h0800};
   int                  errors = 0, cmp_count = 0, cycles = 0;
   lpbk_pkg::rx_src_t   srcs [3] = '{lpbk_pkg::SRC_IDLE, lpbk_pkg::SRC_TX, lpbk_pkg::SRC_SYMBOL};
   always #50 clk = ~clk;
   phy_loopback_bypass_control u_phy_loopback_bypass_control (.CLK(clk), .RESET_N(reset_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3),
      .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err), .CM_STATE(cm),
      .SELF_TEST_RUNNING(st), .TX_BYTE(tx_byte), .TX_VALID(tx_valid), .RECEIVED_SYMBOL_BYTE(sym),
      .PRE_FRAMER_LOOP_SEL(pre), .LINE_MONITOR_LOOP_SEL(lm), .FRAMER_CLOCK_LOCAL_SEL(clk_loc),
      .BYPASS_SOURCE(src), .RX_BYTE(rx_byte), .RX_VALID(rx_valid), .RX_READY(rx_ready),
      .TX_READY(tx_ready));
   lpbk_far_end u_lpbk_far_end (.clk(clk), .reset_n(reset_n), .stall(stall), .freeze(freeze),
      .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .rx_ready(rx_ready));
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_i <= d;
      do @(posedge clk); while (!(ack | err) && ++n < 20);
      `CHECK((ack | err), 1'b1)
      rd      = dat_o;
      got_err = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
      wb(1'b0, a, 32'h0);
      `CHECK(rd[15:0], e)
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         complete_run();
      end
   end
   initial
   begin
      tick(12);
      reset_n <= 1'b1;
      rdchk(6'h00, 16'h0000);
      rdchk(6'h04, 16'h0000);
      wb(1'b0, 6'h0C, 32'h0);
      `CHECK(got_err, 1'b1)
      cm <= lpbk_pkg::CM_ACTIVE;
      tick(4);
      wb(1'b1, 6'h00, 32'h0038);
      rdchk(6'h00, 16'h0008);
      `CHECK(src, lpbk_pkg::SRC_SYMBOL)
      cm <= lpbk_pkg::CM_MAINTENANCE;
      tick(4);
      wb(1'b1, 6'h00, 32'h0030);
      // Receive data may be garbage for a cycle after the clock switch, so wait it out.
      tick(3);
      `CHECK({pre, lm, clk_loc}, 3'b111)
      wb(1'b1, 6'h00, 32'h0000);
      tick(3);
      `CHECK({pre, lm, clk_loc}, 3'b000)
      st <= 1'b1;
      tick(6);
      `CHECK({pre, clk_loc}, 2'b10)
      st     <= 1'b0;
      freeze <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b1, 6'h00, {16'h0, ctl[i]});
         tick(10);
         exp_b = (i == 0) ? lpbk_pkg::IDLE_BYTE : (i == 1) ? tx_byte : sym;
         `CHECK(src, srcs[i])
         `CHECK(rx_byte, exp_b)
      end
      cm <= lpbk_pkg::CM_ACTIVE;
      tick(4);
      wb(1'b1, 6'h00, 32'h0008);
      tick(3);
      `CHECK(src, lpbk_pkg::SRC_SYMBOL)
      wb(1'b1, 6'h04, 32'h8000);
      tick(3);
      `CHECK(src, lpbk_pkg::SRC_TX)
      freeze <= 1'b0;
      stall  <= 1'b1;
      tick(10);
      `CHECK({tx_ready, rx_valid}, 2'b01)
      stall <= 1'b0;
      tick(10);
      `CHECK({tx_ready, rx_valid}, 2'b11)
      complete_run();
   end
endmodule
